// ===== rtl/dcs_pkg.sv
// Functional notes
// - Commands other than deselect take two cycles, decoded at second edge.
// - All-banks flag on precharge closes every bank; refresh ignores it.
// - Auto-precharge flag closes the addressed bank after the access.
// - Burst flag picks 32 or 16 beats when on-the-fly is enabled.
// - Column second halves: C1..C0 zero; writes drive C3..C2 low.
// - Target-refresh control bit 7 enables; bits 6..4 select the bank.
// - Mode self-clears after third bank precharge plus mode delay.
// - Three activates and three precharges; precharge-all counts. Exit here waits on the third precharge only, activates are just counted.
// - Target-bank activates in the mode give no refresh credit.
package dcs_pkg;
   // -------------------------------------------------------------------------
   // Register map (APB byte addresses)
   // -------------------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_STATUS = 8'h04;
   localparam logic [7:0]  ADDR_COUNT  = 8'h08;
   localparam logic [7:0]  ADDR_BANKS  = 8'h0C;
   // -------------------------------------------------------------------------
   // Field positions and reset values
   // -------------------------------------------------------------------------
   localparam int          CTRL_OTF_BIT    = 0;
   localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
   localparam int          TRR_EN_BIT      = 7;
   localparam int          TRR_BANK_LO     = 4;
   localparam int          REPAIR_EN_BIT   = 4;
   localparam logic [5:0]  MA_TRR_CTRL     = 6'h18;
   localparam logic [5:0]  MA_REPAIR       = 6'h04;
   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int          CLK_PERIOD_NS   = 10;
   localparam int          T_MRD_NS        = 14;
   localparam int          T_MRD_CYC       = (T_MRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  T_MRD_CNT       = 4'(T_MRD_CYC);
   // -------------------------------------------------------------------------
   // First-half command codes CA[4:0] (CA0 first)
   // -------------------------------------------------------------------------
   localparam logic [4:0]  OP_MPC   = 5'h00;
   localparam logic [4:0]  OP_PRE   = 5'h10;
   localparam logic [4:0]  OP_REF   = 5'h08;
   localparam logic [4:0]  OP_SRE   = 5'h18;
   localparam logic [4:0]  OP_WR    = 5'h04;
   localparam logic [4:0]  OP_MWR   = 5'h0C;
   localparam logic [4:0]  OP_RD    = 5'h02;
   localparam logic [4:0]  OP_CAS2  = 5'h12;
   localparam logic [4:0]  OP_MRW1  = 5'h06;
   localparam logic [4:0]  OP_MRW2  = 5'h16;
   localparam logic [4:0]  OP_MRR   = 5'h0E;
   // Command kinds seen by the tracker
   typedef enum logic [6:0] {
      DCS_K_NONE = 7'b0000001,
      DCS_K_ACT  = 7'b0000010,
      DCS_K_PRE  = 7'b0000100,
      DCS_K_PREA = 7'b0001000,
      DCS_K_REF  = 7'b0010000,
      DCS_K_COL  = 7'b0100000,
      DCS_K_MRW  = 7'b1000000
   } dcs_kind_t;
endpackage : dcs_pkg

// ===== rtl/dcs_decode.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Two-cycle command assembler: catches first half, merges second half
// ----------------------------------------------------------------------------
module dcs_decode (
   // Clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // Command bus
   input  wire logic                cs,
   input  wire logic [5:0]          ca,
   // Assembled command
   output logic                     cmd_vld,
   output dcs_pkg::dcs_kind_t       cmd_kind,
   output logic [2:0]               cmd_bank,
   output logic                     cmd_all_banks,
   output logic                     cmd_auto_pre,
   output logic                     cmd_burst_flag,
   output logic [5:0]               cmd_ma,
   output logic [7:0]               cmd_op,
   output logic [1:0]               cmd_colz
);
   logic       second_q, second_d;
   logic [5:0] first_q, first_d;
   logic [5:0] ma_q, ma_d;
   logic       op7_q, op7_d;

   // Next-state: first edge with cs high starts a command
   always_comb begin
      second_d = 1'b0;
      first_d  = first_q;
      ma_d     = ma_q;
      op7_d    = op7_q;
      if (!second_q && cs) begin
         second_d = 1'b1;
         first_d  = ca;
      end else if (second_q && first_q[4:0] == dcs_pkg::OP_MRW1) begin
         ma_d  = ca;
         op7_d = first_q[5];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         second_q <= 1'b0;
         first_q  <= 6'h00;
         ma_q     <= 6'h00;
         op7_q    <= 1'b0;
      end else begin
         second_q <= second_d;
         first_q  <= first_d;
         ma_q     <= ma_d;
         op7_q    <= op7_d;
      end
   end

   // Classify at second edge
   always_comb begin
      cmd_vld  = second_q;
      cmd_kind = dcs_pkg::DCS_K_NONE;
      cmd_bank = ca[2:0];
      cmd_all_banks  = first_q[5];
      cmd_auto_pre   = ca[5];
      cmd_burst_flag = first_q[5];
      cmd_ma   = ma_q;
      cmd_op   = {op7_q, first_q[5], ca};
      cmd_colz = 2'b00;
      if (second_q) begin
         if (first_q[0]) // Second activate half carries row bits, not a bank
            cmd_kind = first_q[1] ? dcs_pkg::DCS_K_NONE : dcs_pkg::DCS_K_ACT;
         else begin
            case (first_q[4:0])
               dcs_pkg::OP_PRE:  cmd_kind = first_q[5] ? dcs_pkg::DCS_K_PREA
                                                       : dcs_pkg::DCS_K_PRE;
               dcs_pkg::OP_REF:  cmd_kind = dcs_pkg::DCS_K_REF;
               dcs_pkg::OP_SRE:  cmd_kind = dcs_pkg::DCS_K_REF;
               dcs_pkg::OP_WR,
               dcs_pkg::OP_MWR,
               dcs_pkg::OP_RD:   cmd_kind = dcs_pkg::DCS_K_COL;
               dcs_pkg::OP_MRW2: cmd_kind = dcs_pkg::DCS_K_MRW;
               default:          cmd_kind = dcs_pkg::DCS_K_NONE;
            endcase
         end
      end
   end

   // Second half never starts a new command
   AST_TWO_CYCLE: assert property (@(posedge pclk) disable iff (!presetn)
      cs && !second_q |=> second_q && first_q == $past(ca) ##1 !second_q)
      else $error("command half misaligned");
endmodule // dcs_decode

// ===== rtl/dcs_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Command sequencing: target-row-refresh and repair tracking, APB status
// ----------------------------------------------------------------------------
module dcs_top (
   // APB
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // Command bus
   input  wire logic          cs,
   input  wire logic [5:0]    ca,
   // Bank effects
   output logic [7:0]         bank_close,
   output logic [7:0]         bank_autopre,
   output logic               refresh_credit,
   output logic               burst32,
   output logic               trr_active,
   output logic               repair_active
);
   // ------------------------------------------------------------------------
   // Command assembly
   // ------------------------------------------------------------------------
   logic                cmd_vld;
   dcs_pkg::dcs_kind_t  cmd_kind;
   logic [2:0]          cmd_bank;
   logic                cmd_auto_pre, cmd_burst_flag;
   logic [5:0]          cmd_ma;
   logic [7:0]          cmd_op;

   dcs_decode dcs_decode_inst (
      .pclk           (pclk),
      .presetn        (presetn),
      .cs             (cs),
      .ca             (ca),
      .cmd_vld        (cmd_vld),
      .cmd_kind       (cmd_kind),
      .cmd_bank       (cmd_bank),
      .cmd_all_banks  (),
      .cmd_auto_pre   (cmd_auto_pre),
      .cmd_burst_flag (cmd_burst_flag),
      .cmd_ma         (cmd_ma),
      .cmd_op         (cmd_op),
      .cmd_colz       ()
   );

   // ------------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------------
   typedef enum logic [2:0] {
      DCS_IDLE = 3'b001,
      DCS_RUN  = 3'b010,
      DCS_EXIT = 3'b100
   } dcs_trr_t;

   dcs_trr_t    st_q, st_d;
   logic [2:0]  bank_q, bank_d;
   logic [1:0]  pre_q, pre_d;
   logic [1:0]  act_q, act_d;
   logic [3:0]  dly_q, dly_d;
   logic        rep_q, rep_d;
   logic        otf_q, otf_d;
   logic        burst_q, burst_d;
   logic [7:0]  close_q, close_d;
   logic [7:0]  autopre_q, autopre_d;
   logic        cred_q, cred_d;
   logic [31:0] rdata_q, rdata_d;

   wire mrw_trr = cmd_vld && cmd_kind == dcs_pkg::DCS_K_MRW && cmd_ma == dcs_pkg::MA_TRR_CTRL;
   wire mrw_rep = cmd_vld && cmd_kind == dcs_pkg::DCS_K_MRW && cmd_ma == dcs_pkg::MA_REPAIR;
   wire apb_wr  = psel && penable && pwrite;

   // Next-state for mode tracking and bank effects
   always_comb begin
      st_d    = st_q;
      bank_d  = bank_q;
      pre_d   = pre_q;
      act_d   = act_q;
      dly_d   = (dly_q != 4'h0) ? dly_q - 4'h1 : 4'h0;
      rep_d   = rep_q;
      otf_d   = otf_q;
      burst_d   = burst_q;
      close_d   = 8'h00;
      autopre_d = 8'h00;
      cred_d  = 1'b0;
      if (apb_wr && paddr == dcs_pkg::ADDR_CTRL)
         otf_d = pwdata[dcs_pkg::CTRL_OTF_BIT];
      // All-banks precharge closes every bank, else the addressed one
      if (cmd_kind == dcs_pkg::DCS_K_PREA)
         close_d = 8'hFF;
      else if (cmd_kind == dcs_pkg::DCS_K_PRE)
         close_d = 8'(1) << cmd_bank;
      if (cmd_kind == dcs_pkg::DCS_K_COL && cmd_auto_pre)
         autopre_d = 8'(1) << cmd_bank;
      if (cmd_kind == dcs_pkg::DCS_K_COL)
         burst_d = otf_q ? cmd_burst_flag : 1'b0;
      if (cmd_kind == dcs_pkg::DCS_K_REF && st_q == DCS_IDLE)
         cred_d = 1'b1;
      if (cmd_kind == dcs_pkg::DCS_K_ACT && !(st_q == DCS_RUN && cmd_bank == bank_q))
         cred_d = 1'b0;
      if (mrw_rep)
         rep_d = cmd_op[dcs_pkg::REPAIR_EN_BIT];
      case (st_q)
         DCS_IDLE: begin
            if (mrw_trr && cmd_op[dcs_pkg::TRR_EN_BIT]) begin
               st_d   = DCS_RUN;
               bank_d = cmd_op[dcs_pkg::TRR_BANK_LO +: 3];
               pre_d  = 2'd0;
               act_d  = 2'd0;
            end
         end
         DCS_RUN: begin
            if (mrw_trr && !cmd_op[dcs_pkg::TRR_EN_BIT]) begin
               st_d = DCS_IDLE;
            end else begin
               if (cmd_kind == dcs_pkg::DCS_K_ACT && cmd_bank == bank_q && act_q != 2'd3)
                  act_d = act_q + 2'd1;
               if ((cmd_kind == dcs_pkg::DCS_K_PREA) ||
                   (cmd_kind == dcs_pkg::DCS_K_PRE && cmd_bank == bank_q)) begin
                  pre_d = pre_q + 2'd1;
                  if (pre_q == 2'd2) begin
                     st_d  = DCS_EXIT;
                     dly_d = dcs_pkg::T_MRD_CNT;
                  end
               end
            end
         end
         DCS_EXIT: begin
            if (dly_q == 4'h0)
               st_d = DCS_IDLE;
         end
         default: st_d = DCS_IDLE;
      endcase
   end

   // Read mux
   always_comb begin
      rdata_d = 32'h0000_0000;
      case (paddr)
         dcs_pkg::ADDR_CTRL:   rdata_d = {31'h0, otf_q};
         dcs_pkg::ADDR_STATUS: rdata_d = {24'h0, bank_q, rep_q, burst_q, st_q};
         dcs_pkg::ADDR_COUNT:  rdata_d = {28'h0, act_q, pre_q};
         dcs_pkg::ADDR_BANKS:  rdata_d = {24'h0, close_q};
         default:              rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q    <= DCS_IDLE;
         bank_q  <= 3'h0;
         pre_q   <= 2'h0;
         act_q   <= 2'h0;
         dly_q   <= 4'h0;
         rep_q   <= 1'b0;
         otf_q   <= dcs_pkg::CTRL_RESET[dcs_pkg::CTRL_OTF_BIT];
         burst_q   <= 1'b0;
         close_q   <= 8'h00;
         autopre_q <= 8'h00;
         cred_q  <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         st_q    <= st_d;
         bank_q  <= bank_d;
         pre_q   <= pre_d;
         act_q   <= act_d;
         dly_q   <= dly_d;
         rep_q   <= rep_d;
         otf_q   <= otf_d;
         burst_q   <= burst_d;
         close_q   <= close_d;
         autopre_q <= autopre_d;
         cred_q  <= cred_d;
         rdata_q <= rdata_d;
      end
   end

   // ------------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------------
   assign prdata         = rdata_q;
   assign pready         = psel && penable;
   assign pslverr        = 1'b0;
   assign bank_close     = close_q;
   assign bank_autopre   = autopre_q;
   assign refresh_credit = cred_q;
   assign burst32        = burst_q;
   assign trr_active     = st_q != DCS_IDLE;
   assign repair_active  = rep_q;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   sequence s_third_pre;
      st_q == DCS_RUN && pre_q == 2'd2 &&
      (cmd_kind == dcs_pkg::DCS_K_PREA ||
       (cmd_kind == dcs_pkg::DCS_K_PRE && cmd_bank == bank_q));
   endsequence
   AST_SELF_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_third_pre |=> st_q == DCS_EXIT ##[1:16] st_q == DCS_IDLE)
      else $error("target refresh did not self clear");
   AST_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == DCS_IDLE && mrw_trr && cmd_op[7] |=> st_q == DCS_RUN
      && bank_q == $past(cmd_op[6:4]))
      else $error("target refresh enable not taken");
   AST_PREA_ALL: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_kind == dcs_pkg::DCS_K_PREA |=> bank_close == 8'hFF)
      else $error("all-bank precharge missed a bank");
   AST_AUTOPRE: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_kind == dcs_pkg::DCS_K_COL && cmd_auto_pre |=> bank_autopre[$past(cmd_bank)])
      else $error("auto precharge lost");
   AST_BURST: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_kind == dcs_pkg::DCS_K_COL |=> burst32 == $past(otf_q && cmd_burst_flag))
      else $error("burst length wrong");
   AST_NO_CREDIT: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == DCS_RUN && cmd_kind == dcs_pkg::DCS_K_ACT |=> !refresh_credit)
      else $error("credit given in target refresh");
   AST_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
      st_q == DCS_RUN && cmd_kind == dcs_pkg::DCS_K_PREA && pre_q < 2'd2
      |=> pre_q == $past(pre_q) + 2'd1)
      else $error("precharge-all not counted");
   AST_REPAIR: assert property (@(posedge pclk) disable iff (!presetn)
      mrw_rep |=> repair_active == $past(cmd_op[4]))
      else $error("repair enable not tracked");
endmodule // dcs_top

// ===== bench/dcs_ctrl_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Controller model: drives the two-cycle command bus
// ----------------------------------------------------------------------------
module dcs_ctrl_model (
   // Clock
   input  wire logic       pclk,
   // Command bus
   output logic            cs,
   output logic [5:0]      ca
);
   // Bus idles deselected
   initial begin
      cs = 1'b0;
      ca = 6'h00;
   end
   // First half with cs high, second half, then gap deselect cycles
   task automatic send(input logic [5:0] f, input logic [5:0] s, input int gap);
      @(posedge pclk);
      cs <= 1'b1;
      ca <= f;
      @(posedge pclk);
      cs <= 1'b0;
      ca <= s;
      repeat (gap) begin
         @(posedge pclk);
         ca <= ~ca;   // Idle lines toggle so no stale value is read
      end
   endtask
   // Activate: second half follows the first at once
   task automatic act(input logic [2:0] b);
      send(6'h01, {3'h0, b}, 0);
      send(6'h03, {3'h0, b}, 4);   // (low row bits mirror the bank)
   endtask
   // Per-bank or all-bank precharge
   task automatic pre(input logic all_banks, input logic [2:0] b);
      send({all_banks, dcs_pkg::OP_PRE}, {3'h0, b}, 4);
   endtask
   // Oscillator or calibration multipurpose command: no column second half
   task automatic mpc(input logic [6:0] op);
      send({op[6], dcs_pkg::OP_MPC}, op[5:0], 2);
   endtask
   // All-bank refresh, never issued while the target mode runs
   task automatic refab();
      send({1'b1, dcs_pkg::OP_REF}, 6'h00, 4);
   endtask
   // Column command; callers give masked write a low burst flag
   task automatic col(input logic [4:0] op, input logic burst_flag, input logic [2:0] b,
                      input logic auto_pre);
      send({burst_flag, op}, {auto_pre, 2'b00, b}, 0);
      send({1'b0, dcs_pkg::OP_CAS2}, 6'h00, 4);
   endtask
   // Mode write pair, then the mode delay before anything else
   task automatic mrw(input logic [5:0] ma, input logic [7:0] op);
      send({op[7], dcs_pkg::OP_MRW1}, ma, 0);
      send({op[6], dcs_pkg::OP_MRW2}, op[5:0], int'(dcs_pkg::T_MRD_CNT) + 2);
   endtask
endmodule // dcs_ctrl_model

// ===== bench/dram_command_trr_ppr_sequencing_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Bench: APB register access plus command sequences
// ----------------------------------------------------------------------------
module dram_command_trr_ppr_sequencing_tb;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cs;
   logic [5:0]  ca;
   logic [7:0]  bank_close;
   logic [7:0]  bank_autopre;
   logic        refresh_credit;
   logic        burst32;
   logic        trr_active;
   logic        repair_active;
   logic [7:0]  seen_close;
   logic [7:0]  seen_auto;
   logic        seen_credit;
   logic        clr_now;
   logic [31:0] rd;
   logic [4:0]  ops [3];
   int          errors;
   int          checked;

   dcs_top dcs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cs(cs), .ca(ca), .bank_close(bank_close),
      .bank_autopre(bank_autopre), .refresh_credit(refresh_credit), .burst32(burst32),
      .trr_active(trr_active), .repair_active(repair_active));
   dcs_ctrl_model dcs_ctrl_model_inst (.pclk(pclk), .cs(cs), .ca(ca));

   // 100 MHz clock
   initial pclk = 1'b0;
   always #5 pclk = ~pclk;
   // Pulse capture between clears
   always @(posedge pclk) begin
      if (clr_now) begin
         seen_close  <= 8'h00;
         seen_auto   <= 8'h00;
         seen_credit <= 1'b0;
      end else begin
         seen_close  <= seen_close | bank_close;
         seen_auto   <= seen_auto | bank_autopre;
         seen_credit <= seen_credit | refresh_credit;
      end
   end
   // Clear captures for one edge while the command bus is quiet
   task automatic clr();
      @(posedge pclk);
      clr_now <= 1'b1;
      @(posedge pclk);
      clr_now <= 1'b0;
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);   // Watchdog bounds the wait
      q = prdata;
      chk(32'({pready, pslverr}), 32'h2, "apb answer");
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Verdict and end of run
   task automatic print_verdict();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      errors++;
      print_verdict();
   end
   // ------------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      clr_now = 1'b1;
      errors  = 0;
      checked = 0;
      ops = '{dcs_pkg::OP_WR, dcs_pkg::OP_MWR, dcs_pkg::OP_RD};
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      chk(32'({bank_close, bank_autopre, refresh_credit, burst32, trr_active, repair_active}),
          32'h0, "outputs after reset");
      apb(1'b0, dcs_pkg::ADDR_CTRL, 32'h0, rd);
      chk(rd, dcs_pkg::CTRL_RESET, "ctrl reset");
      apb(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
      apb(1'b0, 8'h40, 32'h0, rd);
      chk(rd, 32'h0, "unmapped read");
      $display("test reset done");
      // Per-bank and all-bank precharge
      for (int b = 0; b < 8; b++) begin
         clr();
         dcs_ctrl_model_inst.pre(1'b0, 3'(b));
         chk(32'(seen_close), 32'(8'h01 << b), "bank precharge");
      end
      clr();
      dcs_ctrl_model_inst.mpc(7'h4B);
      chk(32'(seen_close), 32'h0, "multipurpose closes nothing");
      clr();
      dcs_ctrl_model_inst.pre(1'b1, 3'h5);
      chk(32'(seen_close), 32'h0000_00FF, "all-bank precharge");
      $display("test precharge done");
      // Auto-precharge flag on every column second half
      for (int i = 0; i < 6; i++) begin
         clr();
         dcs_ctrl_model_inst.col(ops[i % 3], 1'b0, 3'h5, 1'(i / 3));
         chk(32'(seen_auto), (i / 3 == 1) ? 32'h20 : 32'h0, "auto-precharge");
      end
      $display("test auto-precharge done");
      // Burst flag, off then on the fly
      dcs_ctrl_model_inst.col(dcs_pkg::OP_RD, 1'b1, 3'h0, 1'b0);
      chk(32'(burst32), 32'h0, "burst with otf off");
      apb(1'b1, dcs_pkg::ADDR_CTRL, 32'h1, rd);
      for (int i = 0; i < 4; i++) begin
         dcs_ctrl_model_inst.col(ops[i % 3], 1'(i % 2 == 0 && i != 1), 3'h2, 1'b0);
         chk(32'(burst32), (i == 0 || i == 2) ? 32'h1 : 32'h0, "burst on the fly");
      end
      $display("test burst done");
      // Refresh credit outside the target mode
      clr();
      dcs_ctrl_model_inst.refab();
      chk(32'(seen_credit), 32'h1, "refresh credit");
      // Full target-row-refresh sequence on bank 3
      clr();
      dcs_ctrl_model_inst.mrw(dcs_pkg::MA_TRR_CTRL, 8'hB0);
      chk(32'(trr_active), 32'h1, "trr entered");
      apb(1'b0, dcs_pkg::ADDR_STATUS, 32'h0, rd);
      chk(32'(rd[7:5]), 32'h3, "trr bank");
      dcs_ctrl_model_inst.act(3'h3);
      repeat (6) @(posedge pclk);
      dcs_ctrl_model_inst.pre(1'b1, 3'h0);
      dcs_ctrl_model_inst.act(3'h3);
      dcs_ctrl_model_inst.pre(1'b0, 3'h6);
      dcs_ctrl_model_inst.pre(1'b0, 3'h3);
      apb(1'b0, dcs_pkg::ADDR_COUNT, 32'h0, rd);
      chk(32'(rd[1:0]), 32'h2, "trr precharge count");
      chk(32'(rd[3:2]), 32'h2, "trr activate count");
      chk(32'(trr_active), 32'h1, "trr still running");
      dcs_ctrl_model_inst.act(3'h3);
      dcs_ctrl_model_inst.pre(1'b0, 3'h3);
      repeat (8) @(posedge pclk);
      chk(32'(trr_active), 32'h0, "trr self clear");
      chk(32'(seen_credit), 32'h0, "no credit in trr");
      $display("test trr done");
      // Abort by clearing the enable, then clear the bank
      dcs_ctrl_model_inst.mrw(dcs_pkg::MA_TRR_CTRL, 8'hE0);
      chk(32'(trr_active), 32'h1, "trr entered again");
      dcs_ctrl_model_inst.mrw(dcs_pkg::MA_TRR_CTRL, 8'h00);
      chk(32'(trr_active), 32'h0, "trr abort");
      repeat (3) dcs_ctrl_model_inst.pre(1'b0, 3'h6);
      chk(32'(trr_active), 32'h0, "abort stays idle");
      $display("test abort done");
      // Row repair procedure
      dcs_ctrl_model_inst.pre(1'b1, 3'h0);
      dcs_ctrl_model_inst.mrw(dcs_pkg::MA_REPAIR, 8'h10);
      chk(32'(repair_active), 32'h1, "repair on");
      apb(1'b0, dcs_pkg::ADDR_STATUS, 32'h0, rd);
      chk(32'(rd[4]), 32'h1, "repair status");
      dcs_ctrl_model_inst.act(3'h1);
      repeat (20) @(posedge pclk);
      dcs_ctrl_model_inst.pre(1'b0, 3'h1);
      dcs_ctrl_model_inst.mrw(dcs_pkg::MA_REPAIR, 8'h00);
      chk(32'(repair_active), 32'h0, "repair off");
      $display("test repair done");
      print_verdict();
   end
endmodule // dram_command_trr_ppr_sequencing_tb
